/* File: testbench/ctm_pin_load.sv */
// Pin load model: the external load hung on the timer output pin.
`timescale 1ns/1ps
`default_nettype none
module ctm_pin_load (
    // Pin from the timer
    input wire logic timer_out_pin,
    input wire logic timer_out_oe,
    // Level seen at the load
    output logic pin_level
);
    // Released pin falls to the pull-down; a stale level would hide a missing enable
    assign pin_level = timer_out_oe ? timer_out_pin : 1'b0;
endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
// Testbench top: APB driver, queued read checks, compare, period and PWM checks.
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import ctm_pkg::*;
;
    localparam logic [31:0] RUN_ON = 32'h1 << CTM_RUN_ON_BIT;
    localparam logic [31:0] RUN_PAUSE = 32'h1 << CTM_RUN_PAUSE_BIT;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, timer_out_pin, timer_out_oe, match_a_flag, match_p_flag, pin_level;
    int n_errors = 0;
    int samples_checked = 0;
    logic [32:0] exp_q[$];
    logic [32:0] e;
    logic [31:0] seed = 32'h1993;
    logic [7:0] mc;
    logic lvl;
    time t1;
    int c;
    logic [7:0] pwm_mc[7] = '{8'hA9, 8'hA0, 8'hAA, 8'hAC, 8'h88, 8'h98, 8'hE8};
    logic [15:0] pwm_ma[7] = '{16'h0040, 16'h0040, 16'h0200, 16'h0040, 16'h0040, 16'h0040,
        16'h0040};
    int pwm_hi[7] = '{256, 768, 512, 768, 0, 1024, 0};

    // ************************************************************
    // Clock, design and pin load
    // ************************************************************
    always #5 clk = ~clk;
    ctm_timer dut_u (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer_out_pin(timer_out_pin), .timer_out_oe(timer_out_oe),
        .match_a_flag(match_a_flag), .match_p_flag(match_p_flag));
    ctm_pin_load load_u (.timer_out_pin(timer_out_pin), .timer_out_oe(timer_out_oe),
        .pin_level(pin_level));

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) check("pready wait", 32'h1, 32'h0);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    // Reads note their expectation; the monitor compares
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic err);
        exp_q.push_back({err, d});
        apb(1'b0, a, 32'h0);
    endtask

    // Timer is stopped before any mode change, then restarted with a rising enable
    task automatic cfg(input logic [7:0] m, input logic [7:0] per, input logic [15:0] ma);
        wr(CTM_ADDR_RUN_CTRL, 32'h0);
        wr(CTM_ADDR_MODE_CTRL, {24'h0, m});
        wr(CTM_ADDR_PERIOD, {24'h0, per});
        wr(CTM_ADDR_MATCH_A, {16'h0, ma});
        wr(CTM_ADDR_FLAGS, 32'h3);
        wr(CTM_ADDR_RUN_CTRL, RUN_ON);
    endtask

    task automatic wait_flag(input logic p, input int lim);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (((p ? match_p_flag : match_a_flag) !== 1'b1) && n < lim);
        if (n >= lim) check("flag wait", 32'h1, 32'h0);
    endtask

    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // Read monitor: oldest note against each completed read
    always @(posedge clk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
            if (exp_q.size() == 0) begin
                check("read queue", 32'h1, 32'h0);
            end else begin
                e = exp_q.pop_front();
                check("read data", e[31:0], prdata);
                check("read error", {31'h0, e[32]}, {31'h0, pslverr});
            end
        end
    end

    // Watchdog, about three times the expected run
    initial begin
        repeat (60000) @(posedge clk);
        n_errors++;
        print_verdict();
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        repeat (8) @(posedge clk);
        check("pin in reset", 32'h0, {31'h0, timer_out_pin});
        rst_b <= 1'b1;
        rd(CTM_ADDR_MODE_CTRL, 32'h0, 1'b0);
        rd(CTM_ADDR_PERIOD, 32'h0, 1'b0);
        repeat (4) begin
            seed = xs(seed);
            wr(CTM_ADDR_MODE_CTRL, {24'h0, seed[7:0]});
            wr(CTM_ADDR_PERIOD, {24'h0, seed[15:8]});
            rd(CTM_ADDR_MODE_CTRL, {24'h0, seed[7:0]}, 1'b0);
            rd(CTM_ADDR_PERIOD, {24'h0, seed[15:8]}, 1'b0);
        end
        rd(8'h1C, 32'h0, 1'b1);
        // Compare mode: every pin function, initial level and inversion
        for (int i = 0; i < 16; i++) begin
            mc = {CTM_MODE_CMP, i[1:0], i[2], i[3], 1'b0, 1'b1};
            cfg(mc, 8'h01, 16'h012C);
            repeat (3) @(posedge clk);
            check("pin initial", {31'h0, i[2] ^ i[3]}, {31'h0, pin_level});
            check("pin enable", 32'h1, {31'h0, timer_out_oe});
            wait_flag(1'b0, 400);
            case (i[1:0])
                2'h0: lvl = i[2];
                2'h1: lvl = 1'b0;
                2'h2: lvl = 1'b1;
                default: lvl = ~i[2];
            endcase
            check("pin on match", {31'h0, lvl ^ i[3]}, {31'h0, pin_level});
            check("flag p", 32'h0, {31'h0, match_p_flag});
        end
        // Clearing source and period spacing of matches
        for (int k = 0; k < 4; k++) begin
            cfg({CTM_MODE_CMP, 5'h00, k >= 2}, (k == 1) ? 8'h02 : 8'h01,
                (k >= 2) ? 16'h0064 : 16'hFFFF);
            if (k == 3) begin
                // Restart with a tick every fourth clock
                wr(CTM_ADDR_RUN_CTRL, 32'h0);
                wr(CTM_ADDR_RUN_CTRL, RUN_ON | 32'h1);
            end
            wait_flag(k < 2, 700);
            t1 = $time;
            wr(CTM_ADDR_FLAGS, 32'h3);
            wait_flag(k < 2, 700);
            check("match spacing", (k == 3) ? 32'd400 : (k == 2) ? 32'd100 : 32'(256 * (k + 1)),
                32'(($time - t1) / 10));
        end
        // Zero period: no clear at 256, no period flag; then a paused restart
        cfg({CTM_MODE_CMP, 6'h00}, 8'h00, 16'h0120);
        wait_flag(1'b0, 400);
        check("flag p zero period", 32'h0, {31'h0, match_p_flag});
        wr(CTM_ADDR_RUN_CTRL, 32'h0);
        wr(CTM_ADDR_RUN_CTRL, RUN_ON | RUN_PAUSE);
        repeat (20) @(posedge clk);
        rd(CTM_ADDR_COUNT, 32'h0, 1'b0);
        rd(CTM_ADDR_RUN_CTRL, RUN_ON | RUN_PAUSE, 1'b0);
        rd(CTM_ADDR_MATCH_A, 32'h0000_0120, 1'b0);
        rd(CTM_ADDR_FLAGS, 32'h1, 1'b0);
        wr(CTM_ADDR_FLAGS, 32'h3);
        rd(CTM_ADDR_FLAGS, 32'h0, 1'b0);
        // PWM waveform, forced levels and timer mode over a 1024-cycle window
        for (int k = 0; k < 7; k++) begin
            cfg(pwm_mc[k], 8'h01, pwm_ma[k]);
            repeat (300) @(posedge clk);
            c = 0;
            repeat (1024) begin
                @(posedge clk);
                if (pin_level === 1'b1) c++;
            end
            check("pwm high cycles", 32'(pwm_hi[k]),
                32'(c));
        end
        check("oe timer mode", 32'h0, {31'h0, timer_out_oe});
        print_verdict();
    end
endmodule
`default_nettype wire

/* File: verilog/ctm_pkg.sv */
// Package: constants, register map and types of the compact timer.
package ctm_pkg;

    // ************************************************************
    // Register map (byte addresses on APB)
    // ************************************************************
    localparam logic [7:0] CTM_ADDR_RUN_CTRL = 8'h00;
    localparam logic [7:0] CTM_ADDR_MODE_CTRL = 8'h04;
    localparam logic [7:0] CTM_ADDR_PERIOD = 8'h08;
    localparam logic [7:0] CTM_ADDR_MATCH_A = 8'h0C;
    localparam logic [7:0] CTM_ADDR_COUNT = 8'h10;
    localparam logic [7:0] CTM_ADDR_FLAGS = 8'h14;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int CTM_RUN_ON_BIT = 3;
    localparam int CTM_RUN_PAUSE_BIT = 7;
    localparam int CTM_FLAG_A_BIT = 0;
    localparam int CTM_FLAG_P_BIT = 1;
    localparam logic [7:0] CTM_RST_MODE_CTRL = 8'h00;
    localparam logic [7:0] CTM_RST_PERIOD = 8'h00;
    localparam logic [15:0] CTM_RST_MATCH_A = 16'h0000;
    localparam logic [1:0] CTM_RST_TICK_SEL = 2'h0;

    // Operating mode codes and pin function codes
    localparam logic [1:0] CTM_MODE_CMP = 2'h0;
    localparam logic [1:0] CTM_MODE_PWM = 2'h2;
    localparam logic [1:0] CTM_MODE_TMR = 2'h3;
    localparam logic [1:0] CTM_PIN_HOLD = 2'h0;
    localparam logic [1:0] CTM_PIN_LOW = 2'h1;
    localparam logic [1:0] CTM_PIN_HIGH = 2'h2;
    localparam logic [1:0] CTM_PIN_TOGGLE = 2'h3;

    // Timer tick divider: log2 step of clk cycles per tick for tick_sel 0..3
    localparam int CTM_TICK_DIV_LOG2_STEP = 2;

    // Mode/output control register layout
    typedef struct packed {
        logic op_mode_sel_hi;
        logic op_mode_sel_lo;
        logic pin_func_sel_hi;
        logic pin_func_sel_lo;
        logic out_init_level;
        logic out_invert;
        logic duty_period_swap;
        logic clear_src_sel;
    } ctm_mode_ctrl_type;

    // Decoded operating mode, one-hot
    typedef enum logic [3:0] {
        CTM_ST_CMP = 4'b0001,
        CTM_ST_PWM = 4'b0010,
        CTM_ST_TMR = 4'b0100,
        CTM_ST_UNDEF = 4'b1000
    } ctm_mode_type;

endpackage

/* File: verilog/ctm_timer.sv */
// Compact 16-bit timer: mode/period control, comparators, output pin, APB slave.
//
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Mode field: 00 compare output, 10 PWM, 11 timer/counter, 01 undefined.
// - Timer/counter mode leaves the pin alone; pin, level, invert bits ignored.
// - Compare mode on match A: 00 hold, 01 low, 10 high, 11 toggle.
// - PWM pin function: 00 inactive, 01 active, 10 waveform, 11 undefined.
// - A match requesting the current initial level shows no pin change.
// - Rising counter enable returns the pin to its initial level.
// - Compare mode initial level: 0 low, 1 high.
// - PWM active level: 0 active low, 1 active high.
// - Invert bit 1 inverts the pin, 0 passes it through.
// - Swap 0: period compare sets period, match A duty; 1 swaps them.
// - Clear source 1 clears on match A; 0 on match P or overflow.
// - Overflow clearing only when the period value is zero.
// - PWM ignores clear source; swap bit picks the clearing comparator.
// - Comparator P checks counter bits 15..8; period is 256 times the value.
// - Enable rising edge zeroes the counter; falling edge holds it.
// - Comparator A compares all sixteen counter bits.
// - Outside PWM mode, with clear source high only the match A flag is raised.
module ctm_timer
    import ctm_pkg::*;
#(
    parameter int CNT_W = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Timer output pin
    output logic timer_out_pin,
    output logic timer_out_oe,
    // Match event flags
    output logic match_a_flag,
    output logic match_p_flag
);

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    if (CNT_W != 16) begin : g_bad_width
        $error("ctm_timer supports only a 16-bit counter");
    end

    // Mode decoding, used by the timer core only; reads return the raw field
    function automatic ctm_mode_type decode_mode(input ctm_mode_ctrl_type c);
        case ({c.op_mode_sel_hi, c.op_mode_sel_lo})
            CTM_MODE_CMP: decode_mode = CTM_ST_CMP;
            CTM_MODE_PWM: decode_mode = CTM_ST_PWM;
            CTM_MODE_TMR: decode_mode = CTM_ST_TMR;
            default: decode_mode = CTM_ST_UNDEF;
        endcase
    endfunction

    // ************************************************************
    // Register file and APB slave
    // ************************************************************
    ctm_mode_ctrl_type mode_ctrl, next_mode_ctrl;
    logic [7:0] period_compare_value, next_period_compare_value;
    logic [15:0] match_a_reg, next_match_a_reg;
    logic counter_on, next_counter_on;
    logic counter_pause, next_counter_pause;
    logic [1:0] tick_sel, next_tick_sel;
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr;
    logic next_match_a_flag, next_match_p_flag;
    logic [15:0] count;
    logic set_a, set_p;
    logic wr_en, rd_addr_ok;

    // Access completes one cycle into the access phase
    assign wr_en = psel && penable && pready && pwrite;

    // Register next values; hardware flag set wins over a write-one clear
    always_comb begin
        next_mode_ctrl = mode_ctrl;
        next_period_compare_value = period_compare_value;
        next_match_a_reg = match_a_reg;
        next_counter_on = counter_on;
        next_counter_pause = counter_pause;
        next_tick_sel = tick_sel;
        next_match_a_flag = match_a_flag;
        next_match_p_flag = match_p_flag;
        next_prdata = 32'h0000_0000;
        next_pready = psel && penable && !pready;
        rd_addr_ok = 1'b1;
        case (paddr)
            CTM_ADDR_RUN_CTRL: next_prdata = {24'h00_0000, counter_pause, 3'h0,
                counter_on, 1'b0, tick_sel};
            CTM_ADDR_MODE_CTRL: next_prdata = {24'h00_0000, mode_ctrl};
            CTM_ADDR_PERIOD: next_prdata = {24'h00_0000, period_compare_value};
            CTM_ADDR_MATCH_A: next_prdata = {16'h0000, match_a_reg};
            CTM_ADDR_COUNT: next_prdata = {16'h0000, count};
            CTM_ADDR_FLAGS: next_prdata = {30'h0000_0000, match_p_flag, match_a_flag};
            default: rd_addr_ok = 1'b0;
        endcase
        next_pslverr = next_pready && !rd_addr_ok;
        if (wr_en) begin
            case (paddr)
                CTM_ADDR_RUN_CTRL: begin
                    next_counter_on = pwdata[CTM_RUN_ON_BIT];
                    next_counter_pause = pwdata[CTM_RUN_PAUSE_BIT];
                    next_tick_sel = pwdata[1:0];
                end
                CTM_ADDR_MODE_CTRL: next_mode_ctrl = pwdata[7:0];
                CTM_ADDR_PERIOD: next_period_compare_value = pwdata[7:0];
                CTM_ADDR_MATCH_A: next_match_a_reg = pwdata[15:0];
                CTM_ADDR_FLAGS: begin
                    if (pwdata[CTM_FLAG_A_BIT]) begin
                        next_match_a_flag = 1'b0;
                    end
                    if (pwdata[CTM_FLAG_P_BIT]) begin
                        next_match_p_flag = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        if (set_a) begin
            next_match_a_flag = 1'b1;
        end
        if (set_p) begin
            next_match_p_flag = 1'b1;
        end
        if (!pready && !next_pready) begin
            next_prdata = prdata;
        end
    end

    // Register stage of the register file
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_ctrl <= CTM_RST_MODE_CTRL;
            period_compare_value <= CTM_RST_PERIOD;
            match_a_reg <= CTM_RST_MATCH_A;
            counter_on <= 1'b0;
            counter_pause <= 1'b0;
            tick_sel <= CTM_RST_TICK_SEL;
            match_a_flag <= 1'b0;
            match_p_flag <= 1'b0;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            mode_ctrl <= next_mode_ctrl;
            period_compare_value <= next_period_compare_value;
            match_a_reg <= next_match_a_reg;
            counter_on <= next_counter_on;
            counter_pause <= next_counter_pause;
            tick_sel <= next_tick_sel;
            match_a_flag <= next_match_a_flag;
            match_p_flag <= next_match_p_flag;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // ************************************************************
    // Timer core
    // ************************************************************
    ctm_mode_type mode;
    logic [5:0] div_cnt, next_div_cnt;
    logic [15:0] next_count, inc;
    logic on_d, tick, on_rise;
    logic cmp_a, cmp_p, ovf, clr;
    logic [1:0] pin_func;
    logic lvl, next_lvl, next_pin, next_oe;
    logic [16:0] duty, period_full;
    logic pwm_active;

    assign mode = decode_mode(mode_ctrl);
    assign pin_func = {mode_ctrl.pin_func_sel_hi, mode_ctrl.pin_func_sel_lo};
    assign on_rise = counter_on && !on_d;
    assign inc = count + 16'h0001;
    // Tick every 1, 4, 16 or 64 clk cycles; one enable pulse, no second clock
    assign tick = counter_on && !counter_pause && !on_rise
        && ((div_cnt & ((6'h01 << (CTM_TICK_DIV_LOG2_STEP * tick_sel)) - 6'h01)) == 6'h00);
    assign cmp_a = (inc == match_a_reg) && (match_a_reg != 16'h0000);
    assign cmp_p = (inc[15:8] == period_compare_value)
        && (inc[7:0] == 8'h00) && (period_compare_value != 8'h00);
    assign ovf = (inc == 16'h0000) && (period_compare_value == 8'h00);
    // Period and duty in counter ticks, 17 bits so that 65536 fits
    assign period_full = (period_compare_value == 8'h00) ? 17'h1_0000
        : {1'b0, period_compare_value, 8'h00};
    assign duty = mode_ctrl.duty_period_swap ? period_full : {1'b0, match_a_reg};
    assign pwm_active = {1'b0, count} < duty;

    // Clearing comparator selection
    always_comb begin
        if (mode == CTM_ST_PWM) begin
            clr = mode_ctrl.duty_period_swap ? cmp_a : (cmp_p || ovf);
        end else if (mode_ctrl.clear_src_sel) begin
            clr = cmp_a;
        end else begin
            clr = cmp_p || ovf;
        end
        set_a = tick && cmp_a;
        set_p = tick && cmp_p && (mode == CTM_ST_PWM || !mode_ctrl.clear_src_sel);
    end

    // Counter, divider and output level next values
    always_comb begin
        next_count = count;
        next_div_cnt = div_cnt + 6'h01;
        next_lvl = lvl;
        if (on_rise) begin
            next_count = 16'h0000;
            next_div_cnt = 6'h01;
            next_lvl = mode_ctrl.out_init_level;
        end else if (tick) begin
            next_count = clr ? 16'h0000 : inc;
        end
        if (!counter_on) begin
            next_div_cnt = 6'h00; // Counter holds while off
        end
        // Match A drives the pin only in compare mode
        if (mode == CTM_ST_CMP && tick && cmp_a && !on_rise) begin
            case (pin_func)
                CTM_PIN_LOW: next_lvl = 1'b0;
                CTM_PIN_HIGH: next_lvl = 1'b1;
                CTM_PIN_TOGGLE: next_lvl = !lvl;
                default: next_lvl = lvl;
            endcase
        end
        // Pin value and drive per mode
        case (mode)
            CTM_ST_CMP: begin
                next_pin = next_lvl ^ mode_ctrl.out_invert;
                next_oe = 1'b1;
            end
            CTM_ST_PWM: begin
                case (pin_func)
                    2'h0: next_pin = !mode_ctrl.out_init_level;
                    2'h1: next_pin = mode_ctrl.out_init_level;
                    2'h2: next_pin = pwm_active ~^ mode_ctrl.out_init_level;
                    default: next_pin = 1'b0; // Undefined code parks the pin at 0, then the invert bit applies
                endcase
                next_pin = next_pin ^ mode_ctrl.out_invert;
                next_oe = 1'b1;
            end
            default: begin
                next_pin = 1'b0;
                next_oe = 1'b0;
            end
        endcase
    end

    // Timer register stage
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count <= 16'h0000;
            div_cnt <= 6'h00;
            on_d <= 1'b0;
            lvl <= 1'b0;
            timer_out_pin <= 1'b0;
            timer_out_oe <= 1'b0;
        end else begin
            count <= next_count;
            div_cnt <= next_div_cnt;
            on_d <= counter_on;
            lvl <= next_lvl;
            timer_out_pin <= next_pin;
            timer_out_oe <= next_oe;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_mode_tmr_float: assert property ((mode == CTM_ST_TMR) |=> !timer_out_oe)
        else $error("pin driven in timer/counter mode");
    a_enable_rise_zero: assert property ($rose(counter_on) |=> count == 16'h0000)
        else $error("counter not zeroed on enable rise");
    a_enable_fall_hold: assert property ((!counter_on && $past(!counter_on))
        |=> $stable(count))
        else $error("counter moved while off");
    a_init_level_set: assert property (($rose(counter_on) && mode == CTM_ST_CMP
        && $stable(mode_ctrl)) |=> timer_out_pin == (mode_ctrl.out_init_level
        ^ mode_ctrl.out_invert))
        else $error("pin not at initial level after enable");
    a_cmp_toggle_pin: assert property ((mode == CTM_ST_CMP
        && pin_func == CTM_PIN_TOGGLE && set_a && !on_rise && $stable(mode_ctrl))
        |=> timer_out_pin != $past(timer_out_pin))
        else $error("pin did not toggle on match A");
    a_cmp_hold_pin: assert property ((mode == CTM_ST_CMP && pin_func == CTM_PIN_HOLD
        && !on_rise && $stable(mode_ctrl)) |=> $stable(timer_out_pin))
        else $error("pin changed with hold function");
    a_period_clear: assert property ((tick && mode != CTM_ST_PWM
        && !mode_ctrl.clear_src_sel && period_compare_value != 8'h00
        && inc == {period_compare_value, 8'h00}) |=> count == 16'h0000)
        else $error("counter not cleared on period match");
    a_no_p_flag: assert property ((mode != CTM_ST_PWM && mode_ctrl.clear_src_sel
        && !match_p_flag) |=> !match_p_flag || !$past(mode_ctrl.clear_src_sel))
        else $error("period flag raised with clear source high");
    a_pwm_force_active: assert property ((mode == CTM_ST_PWM && pin_func == 2'h1)
        |=> timer_out_pin == ($past(mode_ctrl.out_init_level)
        ^ $past(mode_ctrl.out_invert)))
        else $error("forced active level wrong");
    a_pause_holds: assert property ((counter_on && counter_pause && $past(counter_on))
        |=> $stable(count))
        else $error("counter moved while paused");
    a_apb_answer: assert property ((psel && !penable) ##1 (psel && penable)[*2]
        |-> pready) else $error("apb answer late");

    c_cmp_match: cover property (mode == CTM_ST_CMP ##1 set_a);
    c_pwm_run: cover property (mode == CTM_ST_PWM && pin_func == 2'h2 ##1 $changed(timer_out_pin));
    c_overflow: cover property (tick && ovf);
    c_flag_clear_race: cover property (wr_en && paddr == CTM_ADDR_FLAGS && set_a);

endmodule
`default_nettype wire
